// ### tb/usc_decoder_tb.sv
/* Bench for the scheduling section decoder: random messages, commands,
   register checks. Assumes usc_pkg and usc_du_model compiled first. */
`timescale 1ns/1ps
module usc_decoder_tb
	import usc_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0, sel = 4'hF;
	logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
	logic [7:0] od;
	logic ov, ol, ordy, wb_ack_o, hdr_valid_o, sect_valid_o, cmd_valid_o;
	logic drop_o, tx_rx_direction_bit_o, alternate_block_flag_o;
	logic extension_present_flag_o, beam_number_list_off_o;
	logic [3:0] channel_filter_select_o, subframe_number_o;
	logic [3:0] symbol_span_count_o;
	logic [7:0] radio_frame_number_o, section_count_o;
	logic [7:0] user_data_compression_header_o, resource_block_count_o;
	logic [7:0] weight_compression_header_o;
	logic [5:0] slot_number_o, current_symbol_o;
	logic [11:0] section_tag_o, element_select_mask_o;
	logic [9:0] first_resource_block_o;
	logic [14:0] terminal_identifier_o, time_beam_group_o;
	logic [1:0] slot_command_code_o;
	logic [13:0] symbol_direction_pattern_o, symbol_guard_pattern_o;
	logic [13:0] symbol_select_mask_o;
	logic [95:0] hq[$], sq[$], cq[$], g;
	logic [31:0] lasthdr = 32'h0;
	int mismatches = 0, n_tests = 0, ext = 0, nd = 0, edrop = 0, goods = 0;

	usc_decoder dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o, .wb_ack_o, .oct_data_i(od), .oct_valid_i(ov),
		.oct_last_i(ol), .oct_ready_o(ordy), .hdr_valid_o,
		.tx_rx_direction_bit_o, .channel_filter_select_o,
		.radio_frame_number_o, .subframe_number_o, .slot_number_o,
		.section_count_o, .user_data_compression_header_o, .sect_valid_o,
		.section_tag_o, .alternate_block_flag_o, .current_symbol_o,
		.first_resource_block_o, .resource_block_count_o,
		.element_select_mask_o, .symbol_span_count_o,
		.extension_present_flag_o, .terminal_identifier_o, .cmd_valid_o,
		.slot_command_code_o, .symbol_direction_pattern_o,
		.symbol_guard_pattern_o, .symbol_select_mask_o,
		.beam_number_list_off_o, .time_beam_group_o,
		.weight_compression_header_o, .drop_o);
	usc_du_model du (.clk_i, .rst_i, .ready_i(ordy), .data_o(od),
		.valid_o(ov), .last_o(ol));

	always #25 clk_i = ~clk_i;

	task chk(input logic [95:0] gv, input logic [95:0] e, input string m);
		n_tests++;
		if (gv !== e) begin
			mismatches++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk

	task end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task rd(input logic [3:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rdat, e, "register");
	endtask : rd

	task put(input logic [7:0] b);
		du.q.push_back({1'b0, b});
	endtask : put

	task close;
		logic [8:0] t;
		t = du.q.pop_back();
		du.q.push_back({1'b1, t[7:0]});
	endtask : close

	task msg(input logic [2:0] v, input logic [7:0] k, input int ns);
		logic [38:0] h;
		logic [68:0] s;
		logic [5:0] sym;
		logic a, good;
		h = 39'({$urandom, $urandom});
		sym = 6'($urandom);
		h[15:8] = 8'(ns);
		good = (v == 3'h1 && k == 8'h05);
		repeat (8) put(8'($urandom));
		put({h[38], v, h[37:34]});
		put(h[33:26]);
		put({h[25:22], h[21:18]});
		put({h[17:16], sym});
		put(h[15:8]);
		put(k);
		put(h[7:0]);
		put(8'h00);
		if (good) begin
			hq.push_back(96'(h));
			goods++;
			lasthdr = {16'h0, h[15:8], h[33:26]};
		end else
			edrop++;
		for (int i = 0; i < ns; i++) begin
			s = 69'({$urandom, $urandom, $urandom});
			a = 1'($urandom);
			sym = sym + 6'(a);
			s[55:50] = sym;
			put(s[68:61]);
			put({s[60:57], s[56], a, s[49:48]});
			put(s[47:40]);
			put(s[39:32]);
			put(s[31:24]);
			put({s[23:20], s[19:16]});
			put({s[15], s[14:8]});
			put(s[7:0]);
			if (s[15])
				repeat (ext) put(8'hA5);
			if (good)
				sq.push_back(96'(s));
		end
		close();
	endtask : msg

	task drain;
		int n;
		n = 0;
		while ((du.q.size() != 0 || ov === 1'b1) && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 3000) begin
			mismatches++;
			$display("MISMATCH %0t stream stalled", $time);
		end
		repeat (3) @(posedge clk_i);
	endtask : drain

	task cmd(input logic [1:0] c);
		logic [39:0] r;
		r = 40'({$urandom, $urandom});
		r[39:38] = c;
		wb(1'b1, 4'h0, {29'h0, c, 1'b1});
		repeat (24) put(8'($urandom));
		put({2'b00, r[37:32]});
		put(r[31:24]);
		if (c == 2'h2) begin
			put({2'b00, r[23:18]});
			put(r[17:10]);
			cq.push_back(96'(r[39:10]));
		end else begin
			put(r[23:16]);
			put(r[15:8]);
			put(r[7:0]);
			put(8'h00);
			cq.push_back(96'(r));
		end
		close();
		drain();
		wb(1'b1, 4'h0, 32'h1);
	endtask : cmd

	always @(posedge clk_i) begin
		if (hdr_valid_o === 1'b1)
			chk({tx_rx_direction_bit_o, channel_filter_select_o,
				radio_frame_number_o, subframe_number_o, slot_number_o,
				section_count_o, user_data_compression_header_o},
				hq.size() ? hq.pop_front() : '1, "header");
		if (sect_valid_o === 1'b1)
			chk({section_tag_o, alternate_block_flag_o, current_symbol_o,
				first_resource_block_o, resource_block_count_o,
				element_select_mask_o, symbol_span_count_o,
				extension_present_flag_o, terminal_identifier_o},
				sq.size() ? sq.pop_front() : '1, "section");
		if (cmd_valid_o === 1'b1) begin
			if (slot_command_code_o === 2'h2)
				g = {slot_command_code_o, symbol_direction_pattern_o,
					symbol_guard_pattern_o};
			else
				g = {slot_command_code_o, symbol_select_mask_o,
					beam_number_list_off_o, time_beam_group_o,
					weight_compression_header_o};
			chk(g, cq.size() ? cq.pop_front() : '1, "command");
		end
		if (drop_o === 1'b1)
			nd++;
	end

	initial begin
		#2_000_000;
		mismatches++;
		end_of_test();
	end

	initial begin
		void'($urandom(32'h680A));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b1, 4'h2, 32'hFFFF_FFFF);
		rd(4'h2, 32'h0);
		rd(4'h0, 32'h1);
		rd(4'h4, 32'h0);
		rd(4'h8, 32'h0);
		rd(4'hC, 32'h0);
		$display("registers done");
		for (int i = 0; i < 8; i++) begin
			du.slow = 1'(i);
			msg(3'h1, 8'h05, i % 4);
			drain();
		end
		$display("messages done");
		ext = 2;
		wb(1'b1, 4'h0, 32'h0000_0201);
		msg(3'h1, 8'h05, 4);
		drain();
		ext = 0;
		wb(1'b1, 4'h0, 32'h1);
		$display("extension done");
		msg(3'h2, 8'h05, 2);
		msg(3'h1, 8'h06, 2);
		drain();
		wb(1'b0, 4'h4, 32'h0);
		chk(rdat[1:0], 2'b01, "bad flag");
		wb(1'b1, 4'h4, 32'h1);
		wb(1'b0, 4'h4, 32'h0);
		chk(rdat[1:0], 2'b00, "flag clear");
		repeat (12) put(8'($urandom));
		close();
		drain();
		wb(1'b0, 4'h4, 32'h0);
		chk(rdat[1:0], 2'b10, "short flag");
		wb(1'b1, 4'h4, 32'h2);
		wb(1'b1, 4'h0, 32'h0);
		chk(96'(ordy), 0, "ready off");
		wb(1'b1, 4'h0, 32'h1);
		chk(96'(ordy), 1, "ready on");
		msg(3'h1, 8'h05, 1);
		drain();
		$display("bad headers done");
		cmd(2'h1);
		cmd(2'h2);
		$display("commands done");
		rd(4'h8, 32'(goods));
		rd(4'hC, lasthdr);
		rd(4'h4, 32'h0);
		chk(96'(nd), 96'(edrop), "drops");
		chk(96'(hq.size() + sq.size() + cq.size()), 0, "missing");
		end_of_test();
	end
endmodule : usc_decoder_tb

// ### tb/usc_du_model.sv
/* Sender model: streams queued octets, with optional stalls.
   Assumes the bench fills q with {last, octet} entries. */
`timescale 1ns/1ps
module usc_du_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// octet stream
	input wire logic ready_i,
	output logic [7:0] data_o,
	output logic valid_o,
	output logic last_o
);
	logic [8:0] q[$];
	logic slow = 1'b0;
	// held until taken; queue order is msb octet first
	always @(posedge clk_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
			last_o <= 1'b0;
			data_o <= 8'h00;
		end else if (!valid_o || ready_i) begin
			if (valid_o)
				void'(q.pop_front());
			if (q.size() != 0 && !(slow && $urandom_range(2) == 0)) begin
				valid_o <= 1'b1;
				{last_o, data_o} <= q[0];
			end else begin
				valid_o <= 1'b0;
				last_o <= 1'b0;
				// idle line toggles so stale data never looks fresh
				data_o <= ~data_o;
			end
		end
	end
endmodule : usc_du_model

// ### verilog/usc_consts.svh
/*
 * Offsets, field positions, reset values and counts for the scheduling
 * section decoder. Definitions only; included by the package, whose macros the core uses.
 */
`ifndef USC_CONSTS_SVH
`define USC_CONSTS_SVH

// register byte addresses (32-bit words)
`define USC_ADR_CTRL 4'h0
`define USC_ADR_STAT 4'h4
`define USC_ADR_MSGS 4'h8
`define USC_ADR_HDR 4'hC
`define USC_CTRL_RST 32'h0000_0001
// control fields
`define USC_CTRL_EN 0
`define USC_CTRL_CMD_LO 1
`define USC_CTRL_CMD_HI 2
`define USC_CTRL_EXT_LO 8
`define USC_CTRL_EXT_HI 15
// status fields
`define USC_STAT_BAD 0
`define USC_STAT_SHORT 1
// frame layout counts in octets
`define USC_TRANSPORT_LEN 8'h08
`define USC_HDR_LEN 8'h08
`define USC_SECT_LEN 8'h08
`define USC_CMD_SKIP 8'h18
`define USC_CMD_PAT_LEN 8'h04
`define USC_CMD_BEAM_LEN 8'h06
// expected header values and slot command codes
`define USC_VERSION 3'h1
`define USC_KIND_SCHED 8'h05
`define USC_CMD_BEAM 2'h1
`define USC_CMD_DUPLEX 2'h2

`endif

// ### verilog/usc_decoder.sv
/*
 * Radio-unit decoder for scheduling section messages and two slot commands.
 * Assumes a byte stream from logic on clk_i (no crossing), one octet per
 * beat, last beat marked, and a classic Wishbone master for the registers.
 */
// Function
// - format version is three bits; only value 1 is the known format
// - section kind is eight bits; value 5 selects scheduling layout
// - first header octet: direction bit, three-bit version, four-bit filter
// - radio frame number is the full next octet
// - subframe in upper nibble, then six-bit slot straddling octets
// - first symbol number fills low six bits beside slot low bits
// - section count octet; decode exactly that many sections
// - kind octet is followed by user data compression header octet
// - reserved header octet is zero on send, ignored on receive
// - each section starts with twelve-bit section tag, msb first
// - one-bit alternate block flag follows the section tag
// - symbol advance flag; when set increment current symbol first
// - ten-bit first resource block completes the tag/flags word
// - eight-bit count of contiguous resource blocks
// - twelve-bit element mask selects elements within each block
// - four-bit symbol span count in low nibble after mask
// - extension flag in msb, then fifteen-bit terminal identifier
// - duplex command: direction pattern octets 25-26, guard 27-28
// - beam command: mask, list-off flag, group, weight header, reserved
// - extension data follows terminal id before next section
`timescale 1ns/1ps
module usc_decoder
	import usc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// octet stream in
	input wire logic [7:0] oct_data_i,
	input wire logic oct_valid_i,
	input wire logic oct_last_i,
	output logic oct_ready_o,
	// common header out
	output logic hdr_valid_o,
	output logic tx_rx_direction_bit_o,
	output logic [3:0] channel_filter_select_o,
	output logic [7:0] radio_frame_number_o,
	output logic [3:0] subframe_number_o,
	output logic [5:0] slot_number_o,
	output logic [7:0] section_count_o,
	output logic [7:0] user_data_compression_header_o,
	// section out
	output logic sect_valid_o,
	output logic [11:0] section_tag_o,
	output logic alternate_block_flag_o,
	output logic [5:0] current_symbol_o,
	output logic [9:0] first_resource_block_o,
	output logic [7:0] resource_block_count_o,
	output logic [11:0] element_select_mask_o,
	output logic [3:0] symbol_span_count_o,
	output logic extension_present_flag_o,
	output logic [14:0] terminal_identifier_o,
	// slot command out
	output logic cmd_valid_o,
	output logic [1:0] slot_command_code_o,
	output logic [13:0] symbol_direction_pattern_o,
	output logic [13:0] symbol_guard_pattern_o,
	output logic [13:0] symbol_select_mask_o,
	output logic beam_number_list_off_o,
	output logic [14:0] time_beam_group_o,
	output logic [7:0] weight_compression_header_o,
	// errors
	output logic drop_o
);

	usc_state_t state_r;
	logic [31:0] ctrl_r;
	logic bad_r;
	logic short_r;
	logic [15:0] msgs_r;
	logic [7:0] cnt_r;
	logic [7:0] left_r;
	logic [63:0] shf_r;
	logic [63:0] word;
	logic [5:0] sym_r;
	logic ack_r;
	logic take;
	logic wr_stb;
	logic hdr_ok;
	logic hdr_done;
	logic sect_done;
	logic cmd_done;
	logic msg_end;
	logic [1:0] cmd_code;
	logic [7:0] ext_len;
	logic [7:0] cmd_len;

	// write-one-to-clear decode, used for both sticky bits
	function automatic logic w1c(input logic [31:0] d, input int b,
			input logic [3:0] s);
		w1c = d[b] & s[b / 8];
	endfunction : w1c

	assign cmd_code = ctrl_r[`USC_CTRL_CMD_HI:`USC_CTRL_CMD_LO];
	assign ext_len = ctrl_r[`USC_CTRL_EXT_HI:`USC_CTRL_EXT_LO];
	assign cmd_len = (cmd_code == `USC_CMD_BEAM) ? `USC_CMD_BEAM_LEN :
		`USC_CMD_PAT_LEN;
	// stalls the source while the decoder is disabled
	assign oct_ready_o = ctrl_r[`USC_CTRL_EN];
	assign take = oct_valid_i & oct_ready_o;
	// octet msb is bit 7, so shifting in at the bottom keeps msb first
	assign word = {shf_r[55:0], oct_data_i};
	assign hdr_done = take && state_r == ST_HEADER &&
		cnt_r == `USC_HDR_LEN - 8'h01;
	assign sect_done = take && state_r == ST_SECTION &&
		cnt_r == `USC_SECT_LEN - 8'h01;
	assign cmd_done = take && state_r == ST_COMMAND &&
		cnt_r == `USC_CMD_SKIP + cmd_len - 8'h01;
	assign hdr_ok = word[62:60] == `USC_VERSION &&
		word[23:16] == `USC_KIND_SCHED;
	// a message may end after its header, last section, last section's extension data or command body
	assign msg_end = (hdr_done && (!hdr_ok || word[31:24] == 8'h00)) ||
		(sect_done && left_r == 8'h01 && !(word[15] && ext_len != 8'h00)) ||
		(take && state_r == ST_EXTENSION && cnt_r == ext_len - 8'h01 &&
		left_r == 8'h00) || cmd_done;

	// wishbone: one wait cycle, ack for one cycle
	assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
	assign wb_ack_o = ack_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else begin
			case (wb_adr_i)
				`USC_ADR_CTRL: wb_dat_o <= ctrl_r;
				`USC_ADR_STAT: wb_dat_o <= {24'h00_0000, left_r[5:0],
					short_r, bad_r};
				`USC_ADR_MSGS: wb_dat_o <= {16'h0000, msgs_r};
				`USC_ADR_HDR: wb_dat_o <= {16'h0000, section_count_o,
					radio_frame_number_o};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= `USC_CTRL_RST;
		end else if (wr_stb && wb_adr_i == `USC_ADR_CTRL) begin
			for (int i = 0; i < 4; i++) begin
				if (wb_sel_i[i]) begin
					ctrl_r[i * 8 +: 8] <= wb_dat_i[i * 8 +: 8];
				end
			end
		end
	end

	// sticky flags: a new event in the clearing cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bad_r <= 1'b0;
			short_r <= 1'b0;
		end else begin
			if (hdr_done && !hdr_ok) begin
				bad_r <= 1'b1;
			end else if (wr_stb && wb_adr_i == `USC_ADR_STAT &&
					w1c(wb_dat_i, `USC_STAT_BAD, wb_sel_i)) begin
				bad_r <= 1'b0;
			end
			if (take && oct_last_i && state_r != ST_DROP && !msg_end) begin
				short_r <= 1'b1;
			end else if (wr_stb && wb_adr_i == `USC_ADR_STAT &&
					w1c(wb_dat_i, `USC_STAT_SHORT, wb_sel_i)) begin
				short_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shf_r <= 64'h0;
		end else if (take) begin
			shf_r <= word;
		end
	end

	// frame walk; the last beat always returns to the transport header
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_TRANSPORT;
			cnt_r <= 8'h00;
			left_r <= 8'h00;
		end else if (take) begin
			cnt_r <= cnt_r + 8'h01;
			case (state_r)
				ST_TRANSPORT: begin
					if (cmd_code != 2'h0) begin
						state_r <= ST_COMMAND;
					end else if (cnt_r == `USC_TRANSPORT_LEN - 8'h01) begin
						state_r <= ST_HEADER;
						cnt_r <= 8'h00;
					end
				end
				ST_HEADER: begin
					if (hdr_done) begin
						cnt_r <= 8'h00;
						left_r <= word[31:24];
						if (!hdr_ok) begin
							state_r <= ST_DROP;
						end else if (word[31:24] == 8'h00) begin
							state_r <= ST_DROP;
						end else begin
							state_r <= ST_SECTION;
						end
					end
				end
				ST_SECTION: begin
					if (sect_done) begin
						cnt_r <= 8'h00;
						left_r <= left_r - 8'h01;
						if (word[15] && ext_len != 8'h00) begin
							state_r <= ST_EXTENSION;
						end else if (left_r == 8'h01) begin
							state_r <= ST_DROP;
						end
					end
				end
				ST_EXTENSION: begin
					if (cnt_r == ext_len - 8'h01) begin
						cnt_r <= 8'h00;
						state_r <= (left_r == 8'h00) ? ST_DROP : ST_SECTION;
					end
				end
				ST_COMMAND: begin
					if (cmd_done) begin
						state_r <= ST_DROP;
					end
				end
				ST_DROP: begin
					cnt_r <= 8'h00;
				end
				default: state_r <= ST_DROP;
			endcase
			if (oct_last_i) begin
				state_r <= ST_TRANSPORT;
				cnt_r <= 8'h00;
			end
		end
	end

	// header fields; reserved octet word[7:0] is ignored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hdr_valid_o <= 1'b0;
			tx_rx_direction_bit_o <= 1'b0;
			channel_filter_select_o <= 4'h0;
			radio_frame_number_o <= 8'h00;
			subframe_number_o <= 4'h0;
			slot_number_o <= 6'h00;
			section_count_o <= 8'h00;
			user_data_compression_header_o <= 8'h00;
			msgs_r <= 16'h0000;
		end else begin
			hdr_valid_o <= hdr_done & hdr_ok;
			if (hdr_done && hdr_ok) begin
				tx_rx_direction_bit_o <= word[63];
				channel_filter_select_o <= word[59:56];
				radio_frame_number_o <= word[55:48];
				subframe_number_o <= word[47:44];
				slot_number_o <= word[43:38];
				section_count_o <= word[31:24];
				user_data_compression_header_o <= word[15:8];
				msgs_r <= msgs_r + 16'h0001;
			end
		end
	end

	// symbol pointer starts at the header value, advances per section with the advance flag set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sym_r <= 6'h00;
		end else if (hdr_done) begin
			sym_r <= word[37:32];
		end else if (sect_done && word[50]) begin
			sym_r <= sym_r + 6'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sect_valid_o <= 1'b0;
			section_tag_o <= 12'h000;
			alternate_block_flag_o <= 1'b0;
			current_symbol_o <= 6'h00;
			first_resource_block_o <= 10'h000;
			resource_block_count_o <= 8'h00;
			element_select_mask_o <= 12'h000;
			symbol_span_count_o <= 4'h0;
			extension_present_flag_o <= 1'b0;
			terminal_identifier_o <= 15'h0000;
		end else begin
			sect_valid_o <= sect_done;
			if (sect_done) begin
				section_tag_o <= word[63:52];
				alternate_block_flag_o <= word[51];
				current_symbol_o <= word[50] ? sym_r + 6'h01 :
					sym_r;
				first_resource_block_o <= word[49:40];
				resource_block_count_o <= word[39:32];
				element_select_mask_o <= word[31:20];
				symbol_span_count_o <= word[19:16];
				extension_present_flag_o <= word[15];
				terminal_identifier_o <= word[14:0];
			end
		end
	end

	// slot command bodies; word holds octets ending at the last one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_valid_o <= 1'b0;
			slot_command_code_o <= 2'h0;
			symbol_direction_pattern_o <= 14'h0000;
			symbol_guard_pattern_o <= 14'h0000;
			symbol_select_mask_o <= 14'h0000;
			beam_number_list_off_o <= 1'b0;
			time_beam_group_o <= 15'h0000;
			weight_compression_header_o <= 8'h00;
		end else begin
			cmd_valid_o <= cmd_done;
			if (cmd_done) begin
				slot_command_code_o <= cmd_code;
				if (cmd_code == `USC_CMD_BEAM) begin
					symbol_select_mask_o <= word[45:32];
					beam_number_list_off_o <= word[31];
					time_beam_group_o <= word[30:16];
					weight_compression_header_o <= word[15:8];
				end else begin
					symbol_direction_pattern_o <= word[29:16];
					symbol_guard_pattern_o <= word[13:0];
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drop_o <= 1'b0;
		end else begin
			drop_o <= hdr_done & ~hdr_ok;
		end
	end

	bad_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		hdr_done && !hdr_ok && !oct_last_i
		|=> drop_o && bad_r && state_r == ST_DROP)
		else $error("bad header not dropped");
	no_sect_a: assert property (@(posedge clk_i) disable iff (rst_i)
		drop_o |-> !sect_valid_o ##1 !sect_valid_o)
		else $error("section decoded after drop");
	hdr_fields_a: assert property (@(posedge clk_i) disable iff (rst_i)
		hdr_valid_o |-> radio_frame_number_o == $past(word[55:48]) &&
		slot_number_o == $past(word[43:38]))
		else $error("header field misplaced");
	count_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		hdr_valid_o |-> left_r == section_count_o)
		else $error("section count not loaded");
	sym_adv_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sect_done && word[50] |=> current_symbol_o == $past(sym_r) + 6'h01)
		else $error("symbol not advanced");
	sect_tag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sect_done |=> sect_valid_o && section_tag_o == $past(word[63:52]))
		else $error("section tag wrong");
	ext_skip_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sect_done && word[15] && ext_len != 8'h00 && !oct_last_i
		|=> state_r == ST_EXTENSION)
		else $error("extension not skipped");
	last_sect_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sect_done && left_r == 8'h01 && !word[15] |=> state_r != ST_SECTION)
		else $error("too many sections");
	guard_pat_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cmd_done && cmd_code == `USC_CMD_DUPLEX
		|=> symbol_guard_pattern_o == $past(word[13:0]))
		else $error("guard pattern wrong");
	wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !ack_r |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle");

	sect_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
		sect_valid_o && extension_present_flag_o);
	drop_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
		drop_o);
	beam_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
		cmd_valid_o && slot_command_code_o == `USC_CMD_BEAM);

endmodule : usc_decoder

// ### verilog/usc_pkg.sv
/*
 * Types of the scheduling section decoder.
 * Assumes usc_consts.svh is on the include path.
 */
package usc_pkg;
`include "usc_consts.svh"
	typedef enum logic [2:0] {
		ST_TRANSPORT,
		ST_HEADER,
		ST_SECTION,
		ST_EXTENSION,
		ST_COMMAND,
		ST_DROP
	} usc_state_t;
endpackage : usc_pkg
